/* File: tor_thermal_override.sv */
/*
 * Critical temperature override, fan on/off hysteresis, keep-running
 * selection and dynamic minimum temperature stepping for three channels,
 * with its registers behind an AXI4-Lite slave.
 * Assumes temperature readings, the conversion strobe, the step strobe
 * and the automatic and minimum duties come from logic on clk_sys.
 */
// Behaviour
// RQ1 - Any channel above limit forces full duty
// RQ2 - Hold full duty until below limit minus hysteresis
// RQ3 - Hysteresis fields reset to four degrees
// RQ4 - Override ignores all automatic fan settings
// RQ5 - Three critical limit registers, reset 0xA4
// RQ6 - 0x6D holds remote1 and local hysteresis
// RQ7 - 0x6E holds remote2 hysteresis in 7:4
// RQ8 - Hysteresis is four bits, whole degrees
// RQ9 - Software should never program zero hysteresis
// RQ10 - Same hysteresis for override and fan off
// RQ11 - 0x62 bits 7:5 select per-fan keep running
// RQ12 - Bit clear stops fan below min minus hysteresis
// RQ13 - Bit set runs fan at minimum duty
// RQ14 - Keep-running fans ignore the hysteresis; fan_on_r still uses it to switch them from auto to min duty
// RQ15 - Three operating point registers, reset 0xA4
// RQ16 - Operating points are 8-bit whole degrees
// RQ17 - Zone below operating point raises minimum temp
// RQ18 - Zone above operating point lowers minimum temp
// RQ19 - Range fields in 0x5F-0x61 reset to 1100
// RQ20 - Comparisons use the reading's own encoding
// RQ21 - Evaluate per conversion, release strictly below
`timescale 1ns/1ps
`default_nettype none
`include "tor_consts.svh"

module tor_thermal_override #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    // AXI4-Lite write address and data
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Temperature readings and strobes
    input  wire tor_pkg::tor_byte_t    temp_remote1,
    input  wire tor_pkg::tor_byte_t    temp_local,
    input  wire tor_pkg::tor_byte_t    temp_remote2,
    input  wire logic                  conv_done,
    input  wire logic                  dyn_step,
    // Duty demands from the automatic loop
    input  wire tor_pkg::tor_byte_t    auto_duty_one,
    input  wire tor_pkg::tor_byte_t    auto_duty_two,
    input  wire tor_pkg::tor_byte_t    auto_duty_three,
    input  wire tor_pkg::tor_byte_t    min_duty_one,
    input  wire tor_pkg::tor_byte_t    min_duty_two,
    input  wire tor_pkg::tor_byte_t    min_duty_three,
    // Fan drive and critical indication
    output tor_pkg::tor_byte_t         fan_drive_one,
    output tor_pkg::tor_byte_t         fan_drive_two,
    output tor_pkg::tor_byte_t         fan_drive_three,
    output logic                       critical_temp_pin_n,
    // Dynamic minimum temperatures
    output tor_pkg::tor_byte_t         tmin_remote1,
    output tor_pkg::tor_byte_t         tmin_local,
    output tor_pkg::tor_byte_t         tmin_remote2
);
    import tor_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Storage.

    tor_byte_t  op_r     [3];
    tor_byte_t  lim_r    [3];
    tor_byte_t  range_r  [3];
    tor_byte_t  tmin_r   [3];
    tor_byte_t  duty_r   [3];
    tor_byte_t  acou_r;
    tor_byte_t  hyst_a_r;
    tor_byte_t  hyst_b_r;
    logic [2:0] ovr_r;
    logic [2:0] fan_on_r;
    logic       crit_n_r;

    tor_byte_t  temp     [3];
    tor_byte_t  auto_d   [3];
    tor_byte_t  min_d    [3];

    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    logic              aw_full_r;
    logic              w_full_r;
    logic              awready_r;
    logic              wready_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              arready_r;
    logic              rvalid_r;
    logic [31:0]       rdata_r;
    logic [1:0]        rresp_r;

    assign temp   = '{temp_remote1, temp_local, temp_remote2};
    assign auto_d = '{auto_duty_one, auto_duty_two, auto_duty_three};
    assign min_d  = '{min_duty_one, min_duty_two, min_duty_three};

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    // One shared field per channel feeds the override, fan-off and operating point thresholds.
    function automatic tor_hyst_t hyst_of(input int ch);
        case (ch)
            0:       hyst_of = hyst_a_r[`TOR_HYST_HI_MSB:`TOR_HYST_HI_LSB];
            1:       hyst_of = hyst_a_r[`TOR_HYST_LO_MSB:`TOR_HYST_LO_LSB];
            default: hyst_of = hyst_b_r[`TOR_HYST_HI_MSB:`TOR_HYST_HI_LSB];
        endcase // see RQ6 see RQ7 see RQ10
    endfunction

    // True when temp < level - hyst, done as temp + hyst < level in nine
    // bits so a level below the hysteresis can never wrap round.
    function automatic logic below_release(input tor_byte_t t,
                                           input tor_byte_t level,
                                           input tor_hyst_t h);
        below_release = ({1'b0, t} + {5'h00, h}) < {1'b0, level};
    endfunction // see RQ20 see RQ21

    ////////////////////////////////////////////////////////////////////////
    // Bus write channel.

    logic [7:0] wr_idx;
    logic       wr_go;
    logic       wr_hit;

    assign wr_idx = awaddr_r[9:2];
    assign wr_go  = aw_full_r && w_full_r && !bvalid_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            aw_full_r <= 1'b0;
            awready_r <= 1'b0;
            awaddr_r  <= '0;
        end else if (wr_go) begin
            aw_full_r <= 1'b0;
            awready_r <= 1'b1;
        end else if (awready_r && s_axi_awvalid) begin
            aw_full_r <= 1'b1;
            awready_r <= 1'b0;
            awaddr_r  <= s_axi_awaddr;
        end else begin
            awready_r <= !aw_full_r;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            w_full_r <= 1'b0;
            wready_r <= 1'b0;
            wdata_r  <= '0;
            wstrb_r  <= '0;
        end else if (wr_go) begin
            w_full_r <= 1'b0;
            wready_r <= 1'b1;
        end else if (wready_r && s_axi_wvalid) begin
            w_full_r <= 1'b1;
            wready_r <= 1'b0;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
        end else begin
            wready_r <= !w_full_r;
        end
    end

    always_comb begin
        case (wr_idx)
            `TOR_IDX_OP_R1, `TOR_IDX_OP_LOC, `TOR_IDX_OP_R2,
            `TOR_IDX_RANGE_R1, `TOR_IDX_RANGE_LOC, `TOR_IDX_RANGE_R2,
            `TOR_IDX_ACOUSTIC, `TOR_IDX_LIM_R1, `TOR_IDX_LIM_LOC,
            `TOR_IDX_LIM_R2, `TOR_IDX_HYST_A, `TOR_IDX_HYST_B,
            `TOR_IDX_TMIN_R1, `TOR_IDX_TMIN_LOC,
            `TOR_IDX_TMIN_R2: wr_hit = 1'b1;
            default:          wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `TOR_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? `TOR_RESP_OKAY : `TOR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers. Only byte lane 0 carries data.

    logic wr_b0;
    assign wr_b0 = wr_go && wstrb_r[0];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < 3; c++) begin
                op_r[c]    <= `TOR_RST_OP;    // see RQ15
                lim_r[c]   <= `TOR_RST_LIM;   // see RQ5
                range_r[c] <= `TOR_RST_RANGE; // see RQ19
            end
            acou_r   <= `TOR_RST_ACOUSTIC;
            hyst_a_r <= `TOR_RST_HYST_A; // see RQ3
            hyst_b_r <= `TOR_RST_HYST_B; // see RQ3
        end else if (wr_b0) begin
            case (wr_idx)
                `TOR_IDX_OP_R1:     op_r[0]    <= wdata_r[7:0]; // see RQ16
                `TOR_IDX_OP_LOC:    op_r[1]    <= wdata_r[7:0];
                `TOR_IDX_OP_R2:     op_r[2]    <= wdata_r[7:0];
                `TOR_IDX_RANGE_R1:  range_r[0] <= wdata_r[7:0];
                `TOR_IDX_RANGE_LOC: range_r[1] <= wdata_r[7:0];
                `TOR_IDX_RANGE_R2:  range_r[2] <= wdata_r[7:0];
                `TOR_IDX_ACOUSTIC:  acou_r     <= wdata_r[7:0];
                `TOR_IDX_LIM_R1:    lim_r[0]   <= wdata_r[7:0];
                `TOR_IDX_LIM_LOC:   lim_r[1]   <= wdata_r[7:0];
                `TOR_IDX_LIM_R2:    lim_r[2]   <= wdata_r[7:0];
                // Zero is stored as written; it simply removes hysteresis.
                `TOR_IDX_HYST_A:    hyst_a_r   <= wdata_r[7:0]; // see RQ8
                `TOR_IDX_HYST_B: begin
                    hyst_b_r <= {wdata_r[7:4], 4'h0}; // see RQ7 see RQ9
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Dynamic minimum temperature. A software write wins over a step.

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < 3; c++) tmin_r[c] <= `TOR_RST_TMIN;
        end else begin
            for (int c = 0; c < 3; c++) begin
                if (wr_b0 && wr_idx == `TOR_IDX_TMIN_R1 + 8'(c)) begin
                    tmin_r[c] <= wdata_r[7:0];
                end else if (dyn_step) begin
                    if (temp[c] > op_r[c]) begin
                        if (tmin_r[c] != 8'h00) begin
                            tmin_r[c] <= tmin_r[c] - 8'h01; // see RQ18
                        end
                    end else if (below_release(temp[c], op_r[c],
                                               hyst_of(c))) begin
                        if (tmin_r[c] < op_r[c]) begin
                            tmin_r[c] <= tmin_r[c] + 8'h01; // see RQ17
                        end
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Critical override, evaluated once per completed conversion.

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ovr_r <= 3'h0;
        end else if (conv_done) begin
            for (int c = 0; c < 3; c++) begin
                if (temp[c] > lim_r[c]) begin
                    ovr_r[c] <= 1'b1; // see RQ1 see RQ20 see RQ21
                end else if (below_release(temp[c], lim_r[c],
                                           hyst_of(c))) begin
                    ovr_r[c] <= 1'b0; // see RQ2 see RQ10
                end
            end
        end
    end

    // Fan on/off state with the same hysteresis as the override.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fan_on_r <= 3'h0;
        end else if (conv_done) begin
            for (int c = 0; c < 3; c++) begin
                if (temp[c] > tmin_r[c]) begin
                    fan_on_r[c] <= 1'b1;
                end else if (below_release(temp[c], tmin_r[c],
                                           hyst_of(c))) begin
                    fan_on_r[c] <= 1'b0; // see RQ10
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fan drive. The override sits above every other choice and no
    // configuration bit can mask it.

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int f = 0; f < 3; f++) duty_r[f] <= `TOR_DUTY_OFF;
            crit_n_r <= 1'b1;
        end else begin
            crit_n_r <= !(|ovr_r);
            for (int f = 0; f < 3; f++) begin
                if (|ovr_r) begin
                    duty_r[f] <= `TOR_DUTY_FULL; // see RQ1 see RQ4
                end else if (acou_r[`TOR_KEEP_RUN_LSB + f]) begin
                    // Keep-running fans drop to min_d instead of off once fan_on_r clears at the off threshold.
                    duty_r[f] <= fan_on_r[f] ? auto_d[f]
                                             : min_d[f]; // see RQ13 RQ14
                end else if (fan_on_r[f]) begin
                    duty_r[f] <= auto_d[f]; // see RQ11
                end else begin
                    duty_r[f] <= `TOR_DUTY_OFF; // see RQ12
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus read channel.

    logic [7:0]  rd_idx;
    logic [7:0]  rd_val;
    logic        rd_hit;

    assign rd_idx = s_axi_araddr[9:2];

    always_comb begin
        rd_hit = 1'b1;
        rd_val = 8'h00;
        case (rd_idx)
            `TOR_IDX_OP_R1:     rd_val = op_r[0];
            `TOR_IDX_OP_LOC:    rd_val = op_r[1];
            `TOR_IDX_OP_R2:     rd_val = op_r[2];
            `TOR_IDX_RANGE_R1:  rd_val = range_r[0];
            `TOR_IDX_RANGE_LOC: rd_val = range_r[1];
            `TOR_IDX_RANGE_R2:  rd_val = range_r[2];
            `TOR_IDX_ACOUSTIC:  rd_val = acou_r;
            `TOR_IDX_LIM_R1:    rd_val = lim_r[0];
            `TOR_IDX_LIM_LOC:   rd_val = lim_r[1];
            `TOR_IDX_LIM_R2:    rd_val = lim_r[2];
            `TOR_IDX_HYST_A:    rd_val = hyst_a_r;
            `TOR_IDX_HYST_B:    rd_val = hyst_b_r;
            `TOR_IDX_TMIN_R1:   rd_val = tmin_r[0];
            `TOR_IDX_TMIN_LOC:  rd_val = tmin_r[1];
            `TOR_IDX_TMIN_R2:   rd_val = tmin_r[2];
            `TOR_IDX_STATUS:    rd_val = {2'h0, fan_on_r, ovr_r};
            default:            rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= '0;
            rresp_r   <= `TOR_RESP_OKAY;
        end else if (arready_r && s_axi_arvalid) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= {24'h000000, rd_val};
            rresp_r   <= rd_hit ? `TOR_RESP_OKAY : `TOR_RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
        end else begin
            arready_r <= !rvalid_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign s_axi_awready       = awready_r;
    assign s_axi_wready        = wready_r;
    assign s_axi_bvalid        = bvalid_r;
    assign s_axi_bresp         = bresp_r;
    assign s_axi_arready       = arready_r;
    assign s_axi_rvalid        = rvalid_r;
    assign s_axi_rdata         = rdata_r;
    assign s_axi_rresp         = rresp_r;
    assign fan_drive_one       = duty_r[0];
    assign fan_drive_two       = duty_r[1];
    assign fan_drive_three     = duty_r[2];
    assign critical_temp_pin_n = crit_n_r;
    assign tmin_remote1        = tmin_r[0];
    assign tmin_local          = tmin_r[1];
    assign tmin_remote2        = tmin_r[2];

endmodule
`default_nettype wire

/* File: tor_consts.svh */
/*
 * Offsets, field positions, reset values and response codes for the
 * thermal override and hysteresis block.
 * Assumes a single inclusion point per compilation unit.
 */
`ifndef TOR_CONSTS_SVH
`define TOR_CONSTS_SVH

// Register indices; the AXI byte address is four times the index.
`define TOR_IDX_OP_R1      8'h33
`define TOR_IDX_OP_LOC     8'h34
`define TOR_IDX_OP_R2      8'h35
`define TOR_IDX_RANGE_R1   8'h5f
`define TOR_IDX_RANGE_LOC  8'h60
`define TOR_IDX_RANGE_R2   8'h61
`define TOR_IDX_ACOUSTIC   8'h62
`define TOR_IDX_LIM_R1     8'h6a
`define TOR_IDX_LIM_LOC    8'h6b
`define TOR_IDX_LIM_R2     8'h6c
`define TOR_IDX_HYST_A     8'h6d
`define TOR_IDX_HYST_B     8'h6e
`define TOR_IDX_TMIN_R1    8'h70
`define TOR_IDX_TMIN_LOC   8'h71
`define TOR_IDX_TMIN_R2    8'h72
`define TOR_IDX_STATUS     8'h73

// Reset values.
`define TOR_RST_OP         8'ha4
`define TOR_RST_LIM        8'ha4
`define TOR_RST_RANGE      8'hc0
`define TOR_RST_ACOUSTIC   8'h00
`define TOR_RST_HYST_A     8'h44
`define TOR_RST_HYST_B     8'h40
`define TOR_RST_TMIN       8'h80

// Field positions.
`define TOR_HYST_HI_MSB    7
`define TOR_HYST_HI_LSB    4
`define TOR_HYST_LO_MSB    3
`define TOR_HYST_LO_LSB    0
`define TOR_KEEP_RUN_LSB   5

// Duty codes and bus responses.
`define TOR_DUTY_FULL      8'hff
`define TOR_DUTY_OFF       8'h00
`define TOR_RESP_OKAY      2'h0
`define TOR_RESP_SLVERR    2'h2

`endif

/* File: tor_pkg.sv */
/*
 * Types shared by the thermal override and hysteresis block.
 * Assumes nothing of its surroundings.
 */
package tor_pkg;

    typedef logic [7:0] tor_byte_t;
    typedef logic [3:0] tor_hyst_t;

endpackage

/* File: tor_thermal_override_properties.sv */
/*
 * Concurrent checks on the ports of the thermal override block.
 * Assumes one clock, clk_sys, and the active-low reset rst_n.
 */
`timescale 1ns/1ps
`default_nettype none

module tor_thermal_override_properties (
    // Clock and reset
    input wire logic                clk_sys,
    input wire logic                rst_n,
    // Bus handshakes
    input wire logic                s_axi_awvalid,
    input wire logic                s_axi_awready,
    input wire logic                s_axi_wvalid,
    input wire logic                s_axi_wready,
    input wire logic [1:0]          s_axi_bresp,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_bready,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic [31:0]         s_axi_rdata,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready,
    // Thermal side
    input wire logic                conv_done,
    input wire logic                critical_temp_pin_n,
    input wire tor_pkg::tor_byte_t  fan_drive_one,
    input wire tor_pkg::tor_byte_t  fan_drive_two,
    input wire tor_pkg::tor_byte_t  fan_drive_three
);
    import tor_pkg::*;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    a_ovr_full_duty: assert property (
        !critical_temp_pin_n |-> fan_drive_one == 8'hff &&
        fan_drive_two == 8'hff && fan_drive_three == 8'hff)
        else $error("fan drive not full during override");
    // The override moves only on a finished conversion, two edges later.
    a_ovr_set_conv: assert property (
        $fell(critical_temp_pin_n) |-> $past(conv_done, 2))
        else $error("override set without a conversion");
    a_ovr_clr_conv: assert property (
        $rose(critical_temp_pin_n) |-> $past(conv_done, 2))
        else $error("override released without a conversion");
    a_wr_resp_time: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_rd_resp_time: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_rdata_upper: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_ar_blocked: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
endmodule

bind tor_thermal_override tor_thermal_override_properties u_props (.*);
`default_nettype wire

/* File: tor_sensor_model.sv */
/*
 * Behavioural source of the three temperature readings.
 * Assumes the bench calls convert; readings hold between conversions.
 */
`timescale 1ns/1ps
`default_nettype none

module tor_sensor_model (
    // Clock
    input  wire logic           clk_sys,
    // Readings
    output tor_pkg::tor_byte_t  temp_remote1,
    output tor_pkg::tor_byte_t  temp_local,
    output tor_pkg::tor_byte_t  temp_remote2,
    output logic                conv_done
);
    import tor_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    initial begin
        temp_remote1 = 8'h70;
        temp_local = 8'h70;
        temp_remote2 = 8'h70;
        conv_done = 1'b0;
    end

    // Readings use the limit encoding; a result register keeps its level.
    task automatic convert(input tor_byte_t r1, lc, r2);
        @(posedge clk_sys);
        temp_remote1 <= r1;
        temp_local <= lc;
        temp_remote2 <= r2;
        conv_done <= 1'b1;
        @(posedge clk_sys);
        conv_done <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: tor_thermal_override_bench.sv */
/*
 * Self-checking bench for the thermal override block.
 * Assumes the design, its package and tor_consts.svh are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tor_consts.svh"

module tor_thermal_override_bench;
    import tor_pkg::*;

    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0]  s_axi_wstrb = '0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, dyn_step = 1'b0;
    tor_byte_t   auto_duty_one = 8'h51, auto_duty_two = 8'h52;
    tor_byte_t   auto_duty_three = 8'h53, min_duty_one = 8'h21;
    tor_byte_t   min_duty_two = 8'h22, min_duty_three = 8'h23;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire logic   s_axi_rvalid, critical_temp_pin_n, conv_done;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire tor_byte_t   temp_remote1, temp_local, temp_remote2, fan_drive_one;
    wire tor_byte_t   fan_drive_two, fan_drive_three, tmin_remote1;
    wire tor_byte_t   tmin_local, tmin_remote2;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    tor_byte_t   rst_idx [12] = '{`TOR_IDX_OP_R1, `TOR_IDX_OP_LOC,
        `TOR_IDX_OP_R2, `TOR_IDX_RANGE_R1, `TOR_IDX_RANGE_LOC,
        `TOR_IDX_RANGE_R2, `TOR_IDX_ACOUSTIC, `TOR_IDX_LIM_R1,
        `TOR_IDX_LIM_LOC, `TOR_IDX_LIM_R2, `TOR_IDX_HYST_A, `TOR_IDX_HYST_B};
    tor_byte_t   rst_val [12] = '{8'ha4, 8'ha4, 8'ha4, 8'hc0, 8'hc0, 8'hc0,
        8'h00, 8'ha4, 8'ha4, 8'ha4, 8'h44, 8'h40};

    tor_thermal_override #(.ADDR_W(12)) u_dut (.*);
    tor_sensor_model u_sense (.*);

    ////////////////////////////////////////////////////////////////////////
    always #20 clk_sys = ~clk_sys;

    task automatic check(input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic axi_wr(input tor_byte_t idx, input logic [31:0] d,
                          output logic [1:0] resp);
        logic aw_ok = 1'b0, w_ok = 1'b0;
        @(posedge clk_sys);
        s_axi_awaddr <= {2'h0, idx, 2'h0};
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input tor_byte_t idx, output logic [31:0] d,
                          output logic [1:0] resp);
        @(posedge clk_sys);
        s_axi_araddr <= {2'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rd_chk(input tor_byte_t idx, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  resp;
        axi_rd(idx, d, resp);
        check(d, exp);
    endtask

    // Outputs register twice after a conversion; three edges gives margin.
    task automatic conv(input tor_byte_t a, b, c);
        u_sense.convert(a, b, c);
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    task automatic fans(input tor_byte_t a, b, c);
        check(fan_drive_one, a);
        check(fan_drive_two, b);
        check(fan_drive_three, c);
    endtask

    task automatic ovr_seq(input int ch, input tor_byte_t hold_t, rel_t);
        tor_byte_t t [3] = '{8'h70, 8'h70, 8'h70};
        t[ch] = 8'ha5;
        conv(t[0], t[1], t[2]);
        check(critical_temp_pin_n, 1'b0);
        fans(8'hff, 8'hff, 8'hff);
        rd_chk(`TOR_IDX_STATUS, 32'h9 << ch);
        t[ch] = hold_t;
        conv(t[0], t[1], t[2]);
        check(critical_temp_pin_n, 1'b0);
        t[ch] = rel_t;
        conv(t[0], t[1], t[2]);
        check(critical_temp_pin_n, 1'b1);
    endtask

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        logic [31:0] d;
        logic [1:0]  resp;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 12; i++)
            rd_chk(rst_idx[i], {24'h0, rst_val[i]});
        axi_rd(8'h00, d, resp);
        check(resp, 2'h2);
        axi_wr(8'h00, 32'h0, resp);
        check(resp, 2'h2);
        axi_wr(`TOR_IDX_RANGE_R1, 32'h1234_56b0, resp);
        rd_chk(`TOR_IDX_RANGE_R1, 32'hb0);
        axi_wr(`TOR_IDX_HYST_B, 32'h1f, resp);
        rd_chk(`TOR_IDX_HYST_B, 32'h10);
        conv(8'h70, 8'h70, 8'h70);
        fans(8'h00, 8'h00, 8'h00);
        for (int f = 0; f < 3; f++) begin
            axi_wr(`TOR_IDX_ACOUSTIC, 32'h20 << f, resp);
            conv(8'h70, 8'h70, 8'h70);
            fans(f == 0 ? min_duty_one : 8'h00, f == 1 ? min_duty_two : 8'h00,
                 f == 2 ? min_duty_three : 8'h00);
        end
        axi_wr(`TOR_IDX_ACOUSTIC, 32'h0, resp);
        auto_duty_one <= 8'h61;
        conv(8'h90, 8'h90, 8'h90);
        fans(8'h61, auto_duty_two, auto_duty_three);
        conv(8'h7e, 8'h7e, 8'h7e);
        fans(8'h61, auto_duty_two, 8'h00);
        conv(8'h7b, 8'h7b, 8'h7b);
        fans(8'h00, 8'h00, 8'h00);
        ovr_seq(0, 8'ha0, 8'h9f);
        axi_wr(`TOR_IDX_HYST_A, 32'h42, resp);
        ovr_seq(1, 8'ha2, 8'ha1);
        ovr_seq(2, 8'ha3, 8'ha2);
        axi_wr(`TOR_IDX_OP_R1, 32'h90, resp);
        rd_chk(`TOR_IDX_OP_R1, 32'h90);
        conv(8'h95, 8'h70, 8'h70);
        @(posedge clk_sys);
        dyn_step <= 1'b1;
        @(posedge clk_sys);
        dyn_step <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        check(tmin_remote1, 8'h7f);
        check(tmin_local, 8'h81);
        check(tmin_remote2, 8'h81);
        rd_chk(`TOR_IDX_TMIN_R1, 32'h7f);
        print_verdict();
    end
endmodule
`default_nettype wire
